// >>> design/pmbus_params.svh
// Command codes, field positions, reset values and timing counts of the bank.
`ifndef PMBUS_PARAMS_SVH
`define PMBUS_PARAMS_SVH
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_IOUT_FLAGS 8'h7B
`define CMD_INPUT_FLAGS 8'h7C
`define CMD_THERM_FLAGS 8'h7D
`define CMD_COMM_FLAGS 8'h7E
`define CMD_LOG_ERASE 8'hD1
`define CMD_LOG_COUNT 8'hD2
`define CMD_LOG_RECORD 8'hD6
`define CMD_LOG_POINTER 8'hD7
`define CMD_ALERT_SETUP 8'hE0
`define CMD_AUX_SETUP 8'hE1
`define CMD_PG_SETUP 8'hE2
`define ARA_ADDR 7'h0C
`define PEC_POLY 8'h07
`define BIT_IOUT_OC_FAULT 7
`define BIT_IOUT_OC_WARN 5
`define BIT_IN_OV_FAULT 7
`define BIT_IN_UV_FAULT 4
`define BIT_OT_FAULT 7
`define BIT_OT_WARN 6
`define BIT_CML_CMD 7
`define BIT_CML_DATA 6
`define BIT_CML_PEC 5
`define BIT_ARA_EN 4
`define BIT_SEC_AND 1
`define BIT_SEC_POL 0
`define BIT_PG_POL 0
`define MASK_ALERT_SETUP 8'h1F
`define MASK_AUX_SETUP 8'h03
`define MASK_PG_SETUP 8'h01
`define PIN_FN_PG 4'h0
`define PIN_FN_SEC 4'h2
`define RST_ALERT_SETUP 8'h00
`define RST_AUX_SETUP 8'h00
`define RST_PG_SETUP 8'h01
`define LOG_OFS_FIRST 8'h30
`define LOG_RECORDS 20
`define LOG_BLOCK_COUNT 8'h20
`define REC_RUN 6'd9
`define REC_TEMP 6'd13
`define REC_STATUS 6'd15
`define REC_VIN 6'd17
`define REC_IOUT 6'd21
`define ERASE_MS 400
`define CLK_KHZ 250000
`define ERASE_CYC (`ERASE_MS * `CLK_KHZ)
`define RUN_TICK_US 1000
`define RUN_TICK_CYC (`RUN_TICK_US * `CLK_KHZ / 1000)
`endif

// >>> design/pmbus_pkg.sv
// Types shared by the management register bank.
package pmbus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } bus_state_e;
  typedef logic [7:0] byte_t;
endpackage : pmbus_pkg

// >>> design/pmbus_status_config_blackbox.sv
// PMBus slave with status flags, pin configuration and the event log.
// What this block does
// R01 - Output current byte bit 7 reports an overcurrent fault.
// R02 - Output current byte bit 5 reports an overcurrent warning; other bits reserved.
// R03 - Input byte bit 7 reports an input overvoltage fault.
// R04 - Input byte bit 4 reports an input undervoltage fault; other bits reserved.
// R05 - Communication byte bit 5 flags a failed error check byte.
// R06 - With alert setup bit 4 low, the alert response address is ignored.
// R07 - Alert setup bits 3:0 pick power good output or secondary on/off.
// R08 - Aux setup bit 1 gates output with the secondary on/off input.
// R09 - Aux setup bit 0 picks the secondary enable level.
// R10 - Power good setup bit 0 picks output polarity; bits 7:1 zero.
// R11 - Log erase turns output off, clears records, then restarts output.
// R12 - Erase keeps the output off for about 400 ms.
// R13 - Event count command returns the number of stored records.
// R14 - Record command returns the record chosen by the pointer.
// R15 - Record reply is a block read led by byte count 32.
// R16 - Record bytes hold run time, temperature and status word.
// R17 - Record bytes hold input voltage and output current.
// R18 - Pointer 0x30 picks newest record, each step one older, to 0x43.
// R19 - Reserved bits read zero and ignore writes.
// R20 - Flags stay set until a clear faults command.
`timescale 1ns/1ps
`include "pmbus_params.svh"
module pmbus_status_config_blackbox #(
  parameter int ERASE_CYC = `ERASE_CYC,
  parameter int RUN_TICK = `RUN_TICK_CYC,
  parameter int RECS = `LOG_RECORDS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_out,
  output logic alert_oe,
  input wire logic [6:0] addr_in,
  input wire logic prim_on,
  input wire logic mpp_in,
  output logic mpp_out,
  output logic mpp_oe,
  input wire logic power_good,
  input wire logic oc_fault,
  input wire logic oc_warn,
  input wire logic ov_in_fault,
  input wire logic uv_in_fault,
  input wire logic ot_fault,
  input wire logic ot_warn,
  input wire logic [15:0] temp_now,
  input wire logic [15:0] vin_now,
  input wire logic [15:0] iout_now,
  output logic out_enable
);
  localparam int PW = $clog2(RECS);
  localparam int CW = $clog2(RECS + 1);

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `PEC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8

  function automatic logic known(input logic [7:0] c);
    case (c)
      `CMD_CLEAR_FAULTS, `CMD_IOUT_FLAGS, `CMD_INPUT_FLAGS, `CMD_THERM_FLAGS,
      `CMD_COMM_FLAGS, `CMD_LOG_ERASE, `CMD_LOG_COUNT, `CMD_LOG_RECORD,
      `CMD_LOG_POINTER, `CMD_ALERT_SETUP, `CMD_AUX_SETUP, `CMD_PG_SETUP: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : known

  // Link side: the bit shifter runs on the bus clock itself.
  // The byte engine reads it only after the synchronised eighth rise, when it has settled.
  logic [7:0] lk_shift_reg;
  always_ff @(posedge scl_clk) begin
    lk_shift_reg <= {lk_shift_reg[6:0], sda_in};
  end

  // Pin synchronisers; only stage one feeds stage two.
  logic [1:0] scl_sy_reg, sda_sy_reg, prim_sy_reg, mpp_sy_reg, pg_sy_reg;
  logic [6:0] addr_a_reg, addr_b_reg;
  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sy_reg <= 2'h3;
      sda_sy_reg <= 2'h3;
      prim_sy_reg <= 2'h0;
      mpp_sy_reg <= 2'h0;
      pg_sy_reg <= 2'h0;
      addr_a_reg <= 7'h00;
      addr_b_reg <= 7'h00;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (ce) begin
      scl_sy_reg <= {scl_sy_reg[0], scl_clk};
      sda_sy_reg <= {sda_sy_reg[0], sda_in};
      prim_sy_reg <= {prim_sy_reg[0], prim_on};
      mpp_sy_reg <= {mpp_sy_reg[0], mpp_in};
      pg_sy_reg <= {pg_sy_reg[0], power_good};
      addr_a_reg <= addr_in;
      addr_b_reg <= addr_a_reg;
      scl_d_reg <= scl_sy_reg[1];
      sda_d_reg <= sda_sy_reg[1];
    end
  end

  logic scl_s, sda_s, prim_s, mpp_s, pg_s;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s = scl_sy_reg[1];
  assign sda_s = sda_sy_reg[1];
  assign prim_s = prim_sy_reg[1];
  assign mpp_s = mpp_sy_reg[1];
  assign pg_s = pg_sy_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  pmbus_pkg::bus_state_e st_reg;
  logic [3:0] bit_cnt_reg;
  logic [5:0] idx_reg;
  logic [1:0] wn_reg;
  pmbus_pkg::byte_t cmd_reg, wdata_reg, crc_reg, tx_reg, tx_byte;
  logic ack_reg, ara_reg, pec_bad_reg, wr_go_reg;
  logic ev_cmd_reg, ev_dat_reg, ev_pec_reg;
  pmbus_pkg::byte_t io_f_reg, in_f_reg, tm_f_reg, cml_f_reg;
  pmbus_pkg::byte_t alert_setup_reg, aux_setup_reg, pg_setup_reg, ptr_reg;
  logic erasing_reg, out_en_reg, zero_reg;
  logic [31:0] ecnt_reg;
  logic [PW-1:0] wr_ptr_reg;
  logic [CW-1:0] cnt_reg;

  // Byte engine: framing, address match, command and data capture.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= pmbus_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      idx_reg <= 6'h00;
      wn_reg <= 2'h0;
      cmd_reg <= 8'h00;
      wdata_reg <= 8'h00;
      crc_reg <= 8'h00;
      tx_reg <= 8'h00;
      ack_reg <= 1'b0;
      ara_reg <= 1'b0;
      pec_bad_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      ev_cmd_reg <= 1'b0;
      ev_dat_reg <= 1'b0;
      ev_pec_reg <= 1'b0;
    end else if (ce) begin
      wr_go_reg <= 1'b0;
      ev_cmd_reg <= 1'b0;
      ev_dat_reg <= 1'b0;
      ev_pec_reg <= 1'b0;
      if (bus_start) begin
        st_reg <= pmbus_pkg::ST_ADDR;
        bit_cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        ara_reg <= 1'b0;
        // A repeated start after the command keeps the running check byte.
        if (st_reg != pmbus_pkg::ST_WDATA || wn_reg != 2'h0) begin
          crc_reg <= 8'h00;
        end
      end else if (bus_stop) begin
        st_reg <= pmbus_pkg::ST_IDLE;
        if (st_reg == pmbus_pkg::ST_WDATA && !pec_bad_reg) begin
          wr_go_reg <= 1'b1;
        end
      end else if (scl_rise && st_reg != pmbus_pkg::ST_IDLE) begin
        if (bit_cnt_reg == 4'h8) begin
          bit_cnt_reg <= 4'h0;
          if (st_reg == pmbus_pkg::ST_RDATA) begin
            if (sda_s) begin
              st_reg <= pmbus_pkg::ST_IGNORE;
            end
            tx_reg <= tx_byte;
            idx_reg <= idx_reg + 6'h01;
          end
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            crc_reg <= crc8(crc_reg, lk_shift_reg);
            ack_reg <= 1'b0;
            unique case (st_reg)
              pmbus_pkg::ST_ADDR: begin
                idx_reg <= 6'h00;
                if (lk_shift_reg[7:1] == addr_b_reg) begin
                  ack_reg <= 1'b1;
                  st_reg <= lk_shift_reg[0] ? pmbus_pkg::ST_RDATA : pmbus_pkg::ST_CMD;
                end else if (lk_shift_reg == {`ARA_ADDR, 1'b1}
                             && alert_setup_reg[`BIT_ARA_EN]) begin // R06
                  ack_reg <= 1'b1;
                  ara_reg <= 1'b1;
                  st_reg <= pmbus_pkg::ST_RDATA;
                end else begin
                  st_reg <= pmbus_pkg::ST_IGNORE;
                end
              end
              pmbus_pkg::ST_CMD: begin
                cmd_reg <= lk_shift_reg;
                ack_reg <= 1'b1;
                wn_reg <= 2'h0;
                pec_bad_reg <= 1'b0;
                ev_cmd_reg <= !known(lk_shift_reg);
                st_reg <= pmbus_pkg::ST_WDATA;
              end
              pmbus_pkg::ST_WDATA: begin
                ack_reg <= 1'b1;
                if (wn_reg != 2'h3) begin
                  wn_reg <= wn_reg + 2'h1;
                end
                if (wn_reg == 2'h0) begin
                  wdata_reg <= lk_shift_reg;
                end else if (wn_reg == 2'h1) begin
                  if (lk_shift_reg != crc_reg) begin
                    pec_bad_reg <= 1'b1;
                    ev_pec_reg <= 1'b1; // R05
                  end
                end else begin
                  ev_dat_reg <= 1'b1;
                end
              end
              pmbus_pkg::ST_IDLE, pmbus_pkg::ST_RDATA, pmbus_pkg::ST_IGNORE: ;
            endcase
          end
        end
      end
    end
  end

  // Data line drive: changes after a clock fall, and is released at a start or stop.
  logic sda_oe_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      sda_oe_reg <= 1'b0;
    end else if (ce) begin
      if (bus_start || bus_stop) begin
        sda_oe_reg <= 1'b0;
      end else if (scl_fall) begin
        if (st_reg == pmbus_pkg::ST_RDATA && bit_cnt_reg < 4'h8) begin
          sda_oe_reg <= !tx_reg[3'(4'h7 - bit_cnt_reg)];
        end else begin
          sda_oe_reg <= bit_cnt_reg == 4'h8 && ack_reg;
        end
      end
    end
  end

  // Record selection: offset first picks the newest entry.
  logic [7:0] rec_k, rec_t;
  logic [PW-1:0] rec_sel;
  logic rec_ok;
  logic [23:0] rec_run [RECS];
  logic [15:0] rec_tmp [RECS];
  logic [15:0] rec_sw [RECS];
  logic [15:0] rec_vin [RECS];
  logic [15:0] rec_io [RECS];
  pmbus_pkg::byte_t rec_byte;
  always_comb begin
    rec_k = ptr_reg - `LOG_OFS_FIRST; // R18
    rec_ok = rec_k < 8'(cnt_reg);
    rec_t = 8'(wr_ptr_reg) + 8'(RECS) - 8'h01 - rec_k;
    if (rec_t >= 8'(RECS)) begin
      rec_t = rec_t - 8'(RECS);
    end
    rec_sel = PW'(rec_t);
    rec_byte = 8'h00;
    if (rec_ok) begin
      case (idx_reg)
        `REC_RUN: rec_byte = rec_run[rec_sel][7:0]; // R16
        `REC_RUN + 6'd1: rec_byte = rec_run[rec_sel][15:8];
        `REC_RUN + 6'd2: rec_byte = rec_run[rec_sel][23:16];
        `REC_TEMP: rec_byte = rec_tmp[rec_sel][7:0];
        `REC_TEMP + 6'd1: rec_byte = rec_tmp[rec_sel][15:8];
        `REC_STATUS: rec_byte = rec_sw[rec_sel][7:0];
        `REC_STATUS + 6'd1: rec_byte = rec_sw[rec_sel][15:8];
        `REC_VIN: rec_byte = rec_vin[rec_sel][7:0]; // R17
        `REC_VIN + 6'd1: rec_byte = rec_vin[rec_sel][15:8];
        `REC_IOUT: rec_byte = rec_io[rec_sel][7:0];
        `REC_IOUT + 6'd1: rec_byte = rec_io[rec_sel][15:8];
        default: rec_byte = 8'h00;
      endcase
    end
  end

  // Read data for the current command.
  always_comb begin
    tx_byte = 8'h00;
    if (ara_reg) begin
      tx_byte = {addr_b_reg, 1'b1};
    end else begin
      case (cmd_reg)
        `CMD_IOUT_FLAGS: tx_byte = io_f_reg;
        `CMD_INPUT_FLAGS: tx_byte = in_f_reg;
        `CMD_THERM_FLAGS: tx_byte = tm_f_reg;
        `CMD_COMM_FLAGS: tx_byte = cml_f_reg;
        `CMD_LOG_COUNT: tx_byte = 8'(cnt_reg); // R13
        `CMD_LOG_RECORD: tx_byte = idx_reg == 6'h00 ? `LOG_BLOCK_COUNT : rec_byte; // R14 R15
        `CMD_LOG_POINTER: tx_byte = ptr_reg;
        `CMD_ALERT_SETUP: tx_byte = alert_setup_reg;
        `CMD_AUX_SETUP: tx_byte = aux_setup_reg;
        `CMD_PG_SETUP: tx_byte = pg_setup_reg;
        default: tx_byte = 8'h00;
      endcase
    end
  end

  // Completed write transactions.
  logic is_send, is_wr, clr_faults, erase_go, ptr_ok, bad_data, writable;
  always_comb begin
    is_send = wr_go_reg && wn_reg == 2'h0;
    is_wr = wr_go_reg && (wn_reg == 2'h1 || wn_reg == 2'h2);
    ptr_ok = wdata_reg >= `LOG_OFS_FIRST && wdata_reg <= 8'(`LOG_OFS_FIRST + RECS - 1);
    writable = cmd_reg == `CMD_LOG_POINTER || cmd_reg == `CMD_ALERT_SETUP
               || cmd_reg == `CMD_AUX_SETUP || cmd_reg == `CMD_PG_SETUP;
    clr_faults = is_send && cmd_reg == `CMD_CLEAR_FAULTS;
    erase_go = is_send && cmd_reg == `CMD_LOG_ERASE;
    bad_data = (is_send && known(cmd_reg) && !clr_faults && !erase_go)
               || (is_wr && known(cmd_reg) && !writable)
               || (is_wr && cmd_reg == `CMD_LOG_POINTER && !ptr_ok);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alert_setup_reg <= `RST_ALERT_SETUP;
      aux_setup_reg <= `RST_AUX_SETUP;
      pg_setup_reg <= `RST_PG_SETUP;
      ptr_reg <= `LOG_OFS_FIRST;
    end else if (ce && is_wr) begin
      if (cmd_reg == `CMD_ALERT_SETUP) begin
        alert_setup_reg <= wdata_reg & `MASK_ALERT_SETUP; // R19
      end
      if (cmd_reg == `CMD_AUX_SETUP) begin
        aux_setup_reg <= wdata_reg & `MASK_AUX_SETUP; // R19
      end
      if (cmd_reg == `CMD_PG_SETUP) begin
        pg_setup_reg <= wdata_reg & `MASK_PG_SETUP; // R10
      end
      if (cmd_reg == `CMD_LOG_POINTER && ptr_ok) begin
        ptr_reg <= wdata_reg; // R14
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins.
  pmbus_pkg::byte_t set_io, set_in, set_tm, set_cml;
  always_comb begin
    set_io = 8'h00;
    set_in = 8'h00;
    set_tm = 8'h00;
    set_cml = 8'h00;
    set_io[`BIT_IOUT_OC_FAULT] = oc_fault; // R01
    set_io[`BIT_IOUT_OC_WARN] = oc_warn; // R02
    set_in[`BIT_IN_OV_FAULT] = ov_in_fault; // R03
    set_in[`BIT_IN_UV_FAULT] = uv_in_fault; // R04
    set_tm[`BIT_OT_FAULT] = ot_fault;
    set_tm[`BIT_OT_WARN] = ot_warn;
    set_cml[`BIT_CML_CMD] = ev_cmd_reg;
    set_cml[`BIT_CML_DATA] = ev_dat_reg || bad_data;
    set_cml[`BIT_CML_PEC] = ev_pec_reg; // R05
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      io_f_reg <= 8'h00;
      in_f_reg <= 8'h00;
      tm_f_reg <= 8'h00;
      cml_f_reg <= 8'h00;
      alert_oe <= 1'b0;
    end else if (ce) begin
      io_f_reg <= (io_f_reg & {8{!clr_faults}}) | set_io; // R20
      in_f_reg <= (in_f_reg & {8{!clr_faults}}) | set_in; // R20
      tm_f_reg <= (tm_f_reg & {8{!clr_faults}}) | set_tm;
      cml_f_reg <= (cml_f_reg & {8{!clr_faults}}) | set_cml;
      alert_oe <= |{io_f_reg, in_f_reg, tm_f_reg, cml_f_reg};
    end
  end

  // Erase: output held off for the whole erase time, then released.
  logic erase_done;
  assign erase_done = erasing_reg && ecnt_reg == 32'(ERASE_CYC - 1);
  always_ff @(posedge clk) begin
    if (reset) begin
      erasing_reg <= 1'b0;
      ecnt_reg <= 32'h0;
    end else if (ce) begin
      if (erase_go) begin
        erasing_reg <= 1'b1; // R11
        ecnt_reg <= 32'h0;
      end else if (erase_done) begin
        erasing_reg <= 1'b0; // R12
      end else if (erasing_reg) begin
        ecnt_reg <= ecnt_reg + 32'h1;
      end
    end
  end

  // Output enable from primary and optional secondary request.
  logic sec_mode, sec_ok, pw_want, cap;
  assign sec_mode = alert_setup_reg[3:0] == `PIN_FN_SEC && aux_setup_reg[`BIT_SEC_AND]; // R07 R08
  assign sec_ok = !sec_mode || mpp_s == aux_setup_reg[`BIT_SEC_POL]; // R09
  assign pw_want = prim_s && sec_ok;
  assign cap = ce && out_en_reg && !pw_want && !erasing_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      out_en_reg <= 1'b0;
      mpp_oe <= 1'b0;
      mpp_out <= 1'b0;
      zero_reg <= 1'b0;
    end else if (ce) begin
      out_en_reg <= pw_want && !erasing_reg; // R08 R11
      mpp_oe <= alert_setup_reg[3:0] == `PIN_FN_PG; // R07
      mpp_out <= pg_setup_reg[`BIT_PG_POL] ? pg_s : !pg_s; // R10
      zero_reg <= 1'b0;
    end
  end

  // Run time since turn-on in ticks.
  logic [31:0] tick_reg;
  logic [23:0] run_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_reg <= 32'h0;
      run_reg <= 24'h0;
    end else if (ce) begin
      if (!out_en_reg) begin
        tick_reg <= 32'h0;
        if (pw_want && !erasing_reg) begin
          run_reg <= 24'h0;
        end
      end else if (tick_reg == 32'(RUN_TICK - 1)) begin
        tick_reg <= 32'h0;
        run_reg <= run_reg + 24'h1;
      end else begin
        tick_reg <= tick_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (erase_done) begin
        wr_ptr_reg <= '0; // R11
        cnt_reg <= '0;
      end else if (cap) begin
        wr_ptr_reg <= wr_ptr_reg == PW'(RECS - 1) ? '0 : wr_ptr_reg + PW'(1);
        if (cnt_reg != CW'(RECS)) begin
          cnt_reg <= cnt_reg + CW'(1); // R13
        end
      end
    end
  end

  for (genvar g = 0; g < RECS; g++) begin : g_rec
    always_ff @(posedge clk) begin
      if (cap && wr_ptr_reg == PW'(g)) begin
        rec_run[g] <= run_reg; // R16
        rec_tmp[g] <= temp_now;
        rec_sw[g] <= {1'b0, |io_f_reg, |in_f_reg, 1'b0, !pg_s, 3'b000,
                      2'b01, 1'b0, io_f_reg[7], in_f_reg[4], |tm_f_reg, |cml_f_reg, 1'b0};
        rec_vin[g] <= vin_now; // R17
        rec_io[g] <= iout_now;
      end
    end
  end

  assign sda_oe = sda_oe_reg;
  assign sda_out = zero_reg;
  assign alert_out = zero_reg;
  assign out_enable = out_en_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  oc_fault_set_a: assert property (ce && oc_fault |=> io_f_reg[7]) // R01
    else $error("overcurrent fault not flagged");
  reserved_zero_a: assert property (io_f_reg[6] == 1'b0 && io_f_reg[4:0] == 5'h00 // R02
    && in_f_reg[6:5] == 2'h0 && in_f_reg[3:0] == 4'h0 && cml_f_reg[4:0] == 5'h00)
    else $error("reserved status bit set");
  input_flags_a: assert property (ce && ov_in_fault && uv_in_fault // R03
    |=> in_f_reg[7] && in_f_reg[4])
    else $error("input fault not flagged");
  pec_flag_a: assert property (ce && ev_pec_reg |=> cml_f_reg[5]) // R05
    else $error("check byte failure not flagged");
  ara_gate_a: assert property (ara_reg |-> alert_setup_reg[4]) // R06
    else $error("alert address answered while disabled");
  pg_drive_a: assert property (ce && alert_setup_reg[3:0] == 4'h0 |=> mpp_oe // R07
    && mpp_out == ($past(pg_setup_reg[0]) ? $past(pg_s) : !$past(pg_s)))
    else $error("power good pin wrong");
  sec_gate_a: assert property (ce && sec_mode && mpp_s != aux_setup_reg[0] |=> !out_enable) // R08
    else $error("secondary request ignored");
  erase_off_a: assert property (erasing_reg && $past(erasing_reg) |-> !out_enable) // R11
    else $error("output on during erase");
  erase_end_a: assert property ($fell(erasing_reg) |-> cnt_reg == '0 // R12
    && $past(ecnt_reg) == 32'(ERASE_CYC - 1))
    else $error("erase ended early or kept records");
  sticky_flag_a: assert property (in_f_reg[4] && !clr_faults |=> in_f_reg[4]) // R20
    else $error("flag dropped without clear");
  block_count_a: assert property (ara_reg == 1'b0 && cmd_reg == 8'hD6 // R15
    && idx_reg == 6'h00 |-> tx_byte == 8'd32)
    else $error("block count not 32");
  count_max_a: assert property (cnt_reg <= CW'(RECS)) // R13
    else $error("event count overflow");
  erase_seen_c: cover property ($fell(erasing_reg) ##1 out_enable);
  pec_fail_c: cover property (ev_pec_reg);
  record_read_c: cover property (st_reg == pmbus_pkg::ST_RDATA && cmd_reg == 8'hD6
    && idx_reg == 6'd10);
endmodule : pmbus_status_config_blackbox

// >>> dv/pmbus_host.sv
// Bus host model that drives the bus clock and pulls the data line low.
`timescale 1ns/1ps
module pmbus_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves while the clock is low and is sampled in the high phase.
  task automatic slot(input logic b, output logic r);
    scl = 1'b0;
    #20 sda_low = !b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20;
  endtask : slot
  task automatic start();
    logic r;
    slot(1'b1, r);
    sda_low = 1'b1;
    #40;
  endtask : start
  task automatic stop();
    logic r;
    slot(1'b0, r);
    sda_low = 1'b0;
    #40;
  endtask : stop
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      slot(w[i], r[i]);
    end
    slot(a, ack);
  endtask : xfer
endmodule : pmbus_host

// >>> dv/pmbus_status_config_blackbox_tb.sv
// Self-checking bench for the management register bank.
`timescale 1ns/1ps
module pmbus_status_config_blackbox_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sda_low, sda_oe, alert_oe, mpp_out, out_enable, a;
  logic prim_on = 1'b0, mpp_in = 1'b0, pg = 1'b0;
  logic [5:0] flt = 6'h00, f;
  logic [15:0] temp = 16'h0000, vin = 16'h0000, iout = 16'h0000;
  logic [7:0] r;
  logic [7:0] q[$];
  logic [63:0] v;
  logic [63:0] vq[$];
  logic [15:0] tab[9] = '{16'h7B00, 16'h7C00, 16'h7D00, 16'h7E00, 16'hD200, 16'hD730,
    16'hE000, 16'hE100, 16'hE201};
  int err_count = 0, checked = 0, cycles = 0;
  int seed = 32'hD6FA;
  wire sda = !(sda_low | sda_oe);
  always #2 clk = ~clk;
  pmbus_host pmbus_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda));
  pmbus_status_config_blackbox #(.ERASE_CYC(200), .RUN_TICK(10))
    pmbus_status_config_blackbox_inst (
    .clk(clk), .reset(reset), .ce(1'b1), .scl_clk(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .alert_out(), .alert_oe(alert_oe), .addr_in(7'h40), .prim_on(prim_on), .mpp_in(mpp_in),
    .mpp_out(mpp_out), .mpp_oe(), .power_good(pg), .oc_fault(flt[0]), .oc_warn(flt[1]),
    .ov_in_fault(flt[2]), .uv_in_fault(flt[3]), .ot_fault(flt[4]), .ot_warn(flt[5]),
    .temp_now(temp), .vin_now(vin), .iout_now(iout), .out_enable(out_enable));
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic head(input logic [7:0] cmd);
    // Frames start on the falling edge so the bus clock never moves with the sampling edge.
    @(negedge clk);
    pmbus_host_inst.start();
    pmbus_host_inst.xfer(8'h80, 1'b1, r, a);
    pmbus_host_inst.xfer(cmd, 1'b1, r, a);
  endtask : head
  task automatic send(input logic [7:0] cmd, input int n, input logic [7:0] d,
    input logic [7:0] p);
    head(cmd);
    if (n > 0) pmbus_host_inst.xfer(d, 1'b1, r, a);
    if (n > 1) pmbus_host_inst.xfer(p, 1'b1, r, a);
    pmbus_host_inst.stop();
  endtask : send
  task automatic rd(input logic [7:0] cmd, input int n);
    q.delete();
    head(cmd);
    pmbus_host_inst.start();
    pmbus_host_inst.xfer(8'h81, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      pmbus_host_inst.xfer(8'hFF, i == n - 1, r, a);
      q.push_back(r);
    end
    pmbus_host_inst.stop();
  endtask : rd
  task automatic expect_reg(input logic [7:0] cmd, input logic [7:0] exp);
    rd(cmd, 1);
    check(q[0], exp);
  endtask : expect_reg
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    foreach (tab[i]) expect_reg(tab[i][15:8], tab[i][7:0]);
    repeat (3) begin
      f = 6'($random(seed));
      @(posedge clk);
      flt <= f;
      @(posedge clk);
      flt <= 6'h00;
      repeat (4) @(posedge clk);
      check(alert_oe, f != 6'h00);
      @(negedge clk);
      pmbus_host_inst.start();
      pmbus_host_inst.xfer(8'h19, 1'b1, r, a);
      check(a, 1'b1);
      pmbus_host_inst.stop();
      expect_reg(8'h7B, {f[0], 1'b0, f[1], 5'h00});
      expect_reg(8'h7C, {f[2], 2'b00, f[3], 4'h0});
      expect_reg(8'h7D, {f[4], f[5], 6'h00});
      send(8'h03, 0, 8'h00, 8'h00);
      expect_reg(8'h7B, 8'h00);
    end
    send(8'hE0, 1, 8'h10, 8'h00);
    @(negedge clk);
    pmbus_host_inst.start();
    pmbus_host_inst.xfer(8'h19, 1'b1, r, a);
    check(a, 1'b0);
    pmbus_host_inst.xfer(8'hFF, 1'b1, r, a);
    check(r, 8'h81);
    pmbus_host_inst.stop();
    send(8'hE0, 1, 8'h00, 8'h00);
    send(8'hA5, 0, 8'h00, 8'h00);
    send(8'hE2, 2, 8'h00, crc8(24'h80E200) ^ 8'h01);
    expect_reg(8'h7E, 8'hA0);
    expect_reg(8'hE2, 8'h01);
    send(8'h03, 0, 8'h00, 8'h00);
    send(8'hE2, 2, 8'h00, crc8(24'h80E200));
    for (int k = 0; k < 4; k++) begin
      if (k == 2) send(8'hE2, 1, 8'hFF, 8'h00);
      @(posedge clk);
      pg <= k[0];
      repeat (8) @(posedge clk);
      check(mpp_out, k[0] ^ (k < 2));
    end
    expect_reg(8'hE2, 8'h01);
    send(8'hD7, 1, 8'h44, 8'h00);
    expect_reg(8'hD7, 8'h30);
    expect_reg(8'h7E, 8'h40);
    send(8'h03, 0, 8'h00, 8'h00);
    repeat (3) begin
      v = {$random(seed), $random(seed)};
      vq.push_front(v);
      @(posedge clk);
      prim_on <= 1'b1;
      {iout, vin, temp} <= v[47:0];
      repeat (20) @(posedge clk);
      check(out_enable, 1'b1);
      prim_on <= 1'b0;
      repeat (20) @(posedge clk);
    end
    expect_reg(8'hD2, 8'h03);
    for (int p = 0; p < 3; p += 2) begin
      send(8'hD7, 1, 8'h30 + p[7:0], 8'h00);
      rd(8'hD6, 33);
      check(q[0], 8'h20);
      check({q[18], q[17], q[14], q[13]}, vq[p][31:0]);
      check({q[22], q[21], 7'h00, q[15][6]}, {vq[p][47:32], 8'h01});
    end
    @(posedge clk);
    prim_on <= 1'b1;
    send(8'hE0, 1, 8'h02, 8'h00);
    for (int s = 0; s < 2; s++) begin
      send(8'hE1, 1, 8'h02 | s[7:0], 8'h00);
      for (int m = 0; m < 2; m++) begin
        @(posedge clk);
        mpp_in <= m[0];
        repeat (8) @(posedge clk);
        check(out_enable, m[0] == s[0]);
      end
    end
    send(8'hE0, 1, 8'h00, 8'h00);
    check(out_enable, 1'b1);
    send(8'hD1, 0, 8'h00, 8'h00);
    repeat (5) @(posedge clk);
    check(out_enable, 1'b0);
    repeat (185) @(posedge clk);
    check(out_enable, 1'b0);
    repeat (30) @(posedge clk);
    check(out_enable, 1'b1);
    expect_reg(8'hD2, 8'h00);
    complete_run();
  end
endmodule : pmbus_status_config_blackbox_tb
